// ---- qbp_map.vh ----
`ifndef QBP_MAP_VH
`define QBP_MAP_VH

// APB register byte offsets
`define QBP_OFS_LATCH    8'h00
`define QBP_OFS_PIN      8'h04
`define QBP_OFS_RMW      8'h08
`define QBP_OFS_CFG      8'h0c
`define QBP_OFS_EDGE     8'h10
`define QBP_OFS_STATE    8'h14

// Machine cycle: 6 states x 2 phases, one oscillator period each
`define QBP_CYC_LAST     4'hb
`define QBP_CYC_S1P1     4'h0
`define QBP_CYC_S5P1     4'h8
`define QBP_CYC_S5P2     4'h9
`define QBP_CYC_S6P2     4'hb

// Reset values
`define QBP_LATCH_RST    8'hff
`define QBP_CFG_RST      17'h00000

// CFG fields
`define QBP_CFG_ANA_LO   0
`define QBP_CFG_ANA_HI   7
`define QBP_CFG_CMP_LO   8
`define QBP_CFG_CMP_HI   15
`define QBP_CFG_LATE     16

// RMW command fields
`define QBP_RMW_OP_LO    0
`define QBP_RMW_OP_HI    3
`define QBP_RMW_BIT_LO   4
`define QBP_RMW_BIT_HI   6
`define QBP_RMW_ARG_LO   8
`define QBP_RMW_ARG_HI   15
`define QBP_RMW_CARRY    16

// Modify operations
`define QBP_OP_AND       4'h0
`define QBP_OP_OR        4'h1
`define QBP_OP_XOR       4'h2
`define QBP_OP_JBC       4'h3
`define QBP_OP_CPL       4'h4
`define QBP_OP_INC       4'h5
`define QBP_OP_DEC       4'h6
`define QBP_OP_DECREMENT_JUMP_OP      4'h7
`define QBP_OP_MOVC      4'h8
`define QBP_OP_CLR       4'h9
`define QBP_OP_SETB      4'ha
`define QBP_OP_WRITE     4'hb

// Drive state codes
`define QBP_ST_IN_LOW    2'h0
`define QBP_ST_IN_HIGH   2'h1
`define QBP_ST_FORCED    2'h2
`define QBP_ST_OUT_LOW   2'h3

`endif

// ---- qbp_pins.sv ----
`default_nettype none
module qbp_pins (
    input  wire logic       i_mclk,
    input  wire logic       i_reset,
    input  wire logic [7:0] i_pd,
    input  wire logic [7:0] i_pu,
    input  wire logic [7:0] i_weak,
    input  wire logic [7:0] i_trip,
    input  wire logic [7:0] i_ext_low,
    input  wire logic [7:0] i_heavy,
    output var  logic [7:0] o_pin
);
    logic [7:0] drv;
    logic [7:0] hi;
    assign drv = i_pd | i_pu | i_weak | i_trip;
    // Weak pull-up alone cannot lift a heavy load, only hold a high level
    assign hi = ~i_pd & (i_pu | i_trip | (i_weak & (~i_heavy | o_pin)));
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset)
            o_pin <= 8'h00;
        else
            o_pin <= ~i_ext_low & ((drv & hi) | (~drv & ~o_pin)); // Floating pins toggle
    end
endmodule
`default_nettype wire

// ---- qbp_port.v ----
// Contract
// RULE1: Each pin sits in exactly one of four drive states.
// RULE2: Latch zero gives output-low, only the strong pulldown on.
// RULE3: Latch zero-to-one write forces high two cycles, then steady high.
// RULE4: Rewriting one into a one latch changes nothing, no forced pulse.
// RULE5: Latch one as input: pin low gives input-low, high gives input-high.
// RULE6: Trip pull-up only while pin sensed high; off whenever driven low.
// RULE7: After reset pins are input-low with latch one until sensed high.
// RULE8: Software revives a stuck weak pin by writing zero then one.
// RULE9: Push-pull drive only while pin is assigned to compare output.
// RULE10: Analog select bits per pin gate digital use of mixed pins.
// RULE11: Latch updates at S6P2; value reaches pin at next S1P1.
// RULE12: Output buffers capture latch in phase 1, hold through phase 2.
// RULE13: Pin read samples the pin during state 5, phase 1 or 2.
// RULE14: Edge detect samples once per machine cycle, compares with previous.
// RULE15: External levels must hold at least one machine cycle.
// RULE16: Modify operations read the latch; all other reads sample the pin.
// RULE17: Bit modifies read whole latch byte, change one bit, write back.
// RULE18: Port latch resets to all ones.
// RULE19: Pulldown only with latch zero; weak pull-up whenever latch one. Code: compare pins follow i_cmp_level, analog-select pins drop all drive.
// RULE20: Software keeps latch one when alternate function is used.
// RULE21: Pin sense for trip pull-up enters through a synchroniser.
// RULE22: Per-pin pulldown and pull-up enables, updated in phase 1.
//
// Implementation choices: the register offsets and the APB register port.
`include "qbp_map.vh"
`default_nettype none

module qbp_port (
    input  wire        i_mclk,
    input  wire        i_reset,
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    output wire        o_pready,
    output reg  [31:0] o_prdata,
    output wire        o_pslverr,
    input  wire [7:0]  i_pin,
    input  wire [7:0]  i_pin_sense,
    input  wire [7:0]  i_cmp_level,
    output wire [7:0]  o_strong_pulldown,
    output wire [7:0]  o_strong_pullup,
    output wire [7:0]  o_weak_pullup,
    output wire [7:0]  o_trip_pullup,
    output wire [7:0]  o_analog_select
);

    reg  [3:0]  cyc_reg;
    reg  [7:0]  latch_reg;
    reg  [7:0]  buf_reg;
    reg  [16:0] cfg_reg;
    reg         pend_reg;
    reg  [16:0] cmd_reg;
    reg  [7:0]  result_reg;
    reg  [7:0]  pin_smp_reg;
    reg  [7:0]  edge_reg;
    reg  [7:0]  sense_meta_reg;
    reg  [7:0]  sense_sync_reg;
    reg  [7:0]  pd_reg;
    reg  [7:0]  sp_reg;
    reg  [7:0]  wp_reg;
    reg  [7:0]  tp_reg;
    reg  [7:0]  latch_next;
    reg  [7:0]  rmw_val;
    reg  [15:0] state_bits;
    reg         hit;
    wire        acc;
    wire        wr_acc;
    wire        cmd_wr;
    wire        phase1;
    wire        at_s6p2;
    wire        smp_now;
    wire [3:0]  op;
    wire [2:0]  bsel;
    wire [7:0]  arg;
    wire [7:0]  bmask;
    wire [7:0]  ana;
    wire [7:0]  cmp;

    // Register decode, edge and command helpers
    wire        apply;
    wire        sel_latch;
    wire        sel_pin;
    wire        sel_rmw;
    wire        sel_cfg;
    wire        sel_edge;
    wire        sel_state;
    wire [7:0]  pin_now;
    wire [7:0]  edge_clr;
    wire [7:0]  edge_set;
    wire [16:0] wr_cmd;
    reg  [7:0]  edge_next;
    reg  [3:0]  cyc_next;

    // One decode per register keeps read mux and write side in step
    assign sel_latch = (i_paddr == `QBP_OFS_LATCH);
    assign sel_pin   = (i_paddr == `QBP_OFS_PIN);
    assign sel_rmw   = (i_paddr == `QBP_OFS_RMW);
    assign sel_cfg   = (i_paddr == `QBP_OFS_CFG);
    assign sel_edge  = (i_paddr == `QBP_OFS_EDGE);
    assign sel_state = (i_paddr == `QBP_OFS_STATE);

    assign acc     = i_psel & i_penable;
    assign cmd_wr  = i_pwrite & (sel_latch | sel_rmw);
    // Stall a new latch command until the pending one lands at S6P2
    assign o_pready  = ~(cmd_wr & pend_reg);
    assign wr_acc    = acc & i_pwrite & o_pready;
    assign o_pslverr = ~hit;
    assign phase1  = ~cyc_reg[0];
    assign at_s6p2 = (cyc_reg == `QBP_CYC_S6P2);
    assign smp_now = cfg_reg[`QBP_CFG_LATE] ? (cyc_reg == `QBP_CYC_S5P2) :
                                             (cyc_reg == `QBP_CYC_S5P1); // RULE13
    assign op    = cmd_reg[`QBP_RMW_OP_HI:`QBP_RMW_OP_LO];
    assign bsel  = cmd_reg[`QBP_RMW_BIT_HI:`QBP_RMW_BIT_LO];
    assign arg   = cmd_reg[`QBP_RMW_ARG_HI:`QBP_RMW_ARG_LO];
    assign bmask = 8'h01 << bsel;
    assign ana   = cfg_reg[`QBP_CFG_ANA_HI:`QBP_CFG_ANA_LO];
    assign cmp   = cfg_reg[`QBP_CFG_CMP_HI:`QBP_CFG_CMP_LO];

    // Pending command retires only at the end of the machine cycle
    assign apply   = pend_reg & at_s6p2;
    // Analog pins read as zero so a floating level sets no edge flag
    assign pin_now  = i_pin & ~ana;
    assign edge_clr = (wr_acc & sel_edge) ? i_pwdata[7:0] : 8'h00;
    assign edge_set = smp_now ? (pin_now ^ pin_smp_reg) : 8'h00; // RULE14
    // Plain latch write travels as a write command, so it waits for S6P2 too
    assign wr_cmd   = {1'b0, i_pwdata[7:0], 4'h0, `QBP_OP_WRITE};

    assign o_strong_pulldown = pd_reg;
    assign o_strong_pullup   = sp_reg;
    assign o_weak_pullup     = wp_reg;
    assign o_trip_pullup     = tp_reg;
    assign o_analog_select   = ana; // RULE10

    // Machine cycle sequencer: twelve clocks, S1P1 first
    always @* begin
        if (cyc_reg == `QBP_CYC_LAST) begin
            cyc_next = `QBP_CYC_S1P1;
        end else begin
            cyc_next = cyc_reg + 4'h1;
        end
    end

    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            cyc_reg <= `QBP_CYC_S1P1;
        end else begin
            cyc_reg <= cyc_next;
        end
    end

    // Modify ops work on the latch, never on the pin level
    always @* begin
        rmw_val = latch_reg; // RULE16 RULE17
        case (op)
            `QBP_OP_AND: begin
                rmw_val = latch_reg & arg;
            end
            `QBP_OP_OR: begin
                rmw_val = latch_reg | arg;
            end
            `QBP_OP_XOR: begin
                rmw_val = latch_reg ^ arg;
            end
            `QBP_OP_JBC: begin
                rmw_val = latch_reg & ~bmask;
            end
            `QBP_OP_CPL: begin
                rmw_val = latch_reg ^ bmask;
            end
            `QBP_OP_INC: begin
                rmw_val = latch_reg + 8'h01;
            end
            `QBP_OP_DEC: begin
                rmw_val = latch_reg - 8'h01;
            end
            `QBP_OP_DECREMENT_JUMP_OP: begin
                rmw_val = latch_reg - 8'h01;
            end
            `QBP_OP_MOVC: begin
                if (cmd_reg[`QBP_RMW_CARRY]) begin
                    rmw_val = latch_reg | bmask;
                end else begin
                    rmw_val = latch_reg & ~bmask;
                end
            end
            `QBP_OP_CLR: begin
                rmw_val = latch_reg & ~bmask;
            end
            `QBP_OP_SETB: begin
                rmw_val = latch_reg | bmask;
            end
            `QBP_OP_WRITE: begin
                rmw_val = arg;
            end
            default: begin
                rmw_val = latch_reg;
            end
        endcase
    end

    always @* begin
        latch_next = latch_reg;
        if (apply) begin
            latch_next = rmw_val; // RULE11
        end
    end

    // Latch, command slot and configuration
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            latch_reg  <= `QBP_LATCH_RST; // RULE18 RULE7
            pend_reg   <= 1'b0;
            cmd_reg    <= 17'h00000;
            result_reg <= 8'h00;
            cfg_reg    <= `QBP_CFG_RST;
        end else begin
            latch_reg <= latch_next;
            if (apply) begin
                pend_reg   <= 1'b0;
                result_reg <= latch_reg; // Old byte, e.g. bit test for jump ops
            end
            // Stall rather than queue: at most one latch command is pending
            if (wr_acc && sel_latch) begin
                pend_reg <= 1'b1;
                cmd_reg  <= wr_cmd;
            end
            if (wr_acc && sel_rmw) begin
                pend_reg <= 1'b1;
                cmd_reg  <= i_pwdata[16:0];
            end
            if (wr_acc && sel_cfg) begin
                cfg_reg <= i_pwdata[16:0];
            end
        end
    end

    // Set beats a same-cycle clear, so no edge is lost to a late clear
    always @* begin
        edge_next = (edge_reg & ~edge_clr) | edge_set; // RULE14
    end

    // Pin sampling and edge flags
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            pin_smp_reg <= 8'hff;
            edge_reg    <= 8'h00;
        end else begin
            if (smp_now) begin
                pin_smp_reg <= pin_now; // RULE13
            end
            edge_reg <= edge_next; // RULE14 RULE15
        end
    end

    // Sense level is analog in silicon; here it is an async digital input
    always @(posedge i_mclk or posedge i_reset) begin
        if (i_reset) begin
            sense_meta_reg <= 8'h00;
            sense_sync_reg <= 8'h00;
        end else begin
            sense_meta_reg <= i_pin_sense; // RULE21
            sense_sync_reg <= sense_meta_reg;
        end
    end

    // Per-pin driver control
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pin
            always @(posedge i_mclk or posedge i_reset) begin
                if (i_reset) begin
                    buf_reg[g] <= 1'b1;
                    pd_reg[g]  <= 1'b0;
                    sp_reg[g]  <= 1'b0;
                    wp_reg[g]  <= 1'b1; // RULE7
                    tp_reg[g]  <= 1'b0;
                end else if (phase1) begin
                    buf_reg[g] <= latch_reg[g]; // RULE12 RULE11
                    if (ana[g]) begin
                        pd_reg[g] <= 1'b0;
                        sp_reg[g] <= 1'b0;
                        wp_reg[g] <= 1'b0;
                        tp_reg[g] <= 1'b0;
                    end else if (cmp[g] && latch_reg[g]) begin
                        // Push-pull: full drive both ways from compare level
                        pd_reg[g] <= ~i_cmp_level[g]; // RULE9 RULE20
                        sp_reg[g] <= i_cmp_level[g];
                        wp_reg[g] <= i_cmp_level[g];
                        tp_reg[g] <= i_cmp_level[g];
                    end else begin
                        pd_reg[g] <= ~latch_reg[g]; // RULE2 RULE19 RULE22
                        wp_reg[g] <= latch_reg[g]; // RULE19
                        // Only a 0-to-1 buffer change pulses; lasts to next phase 1
                        sp_reg[g] <= latch_reg[g] & ~buf_reg[g]; // RULE3 RULE4 RULE8
                        tp_reg[g] <= latch_reg[g] & sense_sync_reg[g]; // RULE6 RULE5
                    end
                end
            end

            always @* begin
                if (pd_reg[g]) begin
                    state_bits[2*g+1:2*g] = `QBP_ST_OUT_LOW; // RULE1
                end else if (sp_reg[g]) begin
                    state_bits[2*g+1:2*g] = `QBP_ST_FORCED;
                end else if (tp_reg[g]) begin
                    state_bits[2*g+1:2*g] = `QBP_ST_IN_HIGH;
                end else begin
                    state_bits[2*g+1:2*g] = `QBP_ST_IN_LOW;
                end
            end
        end
    endgenerate

    // Read mux
    always @* begin
        hit      = 1'b1;
        o_prdata = 32'h00000000;
        if (sel_latch) begin
            o_prdata = {24'h000000, latch_reg}; // RULE16
        end else if (sel_pin) begin
            o_prdata = {24'h000000, pin_smp_reg};
        end else if (sel_rmw) begin
            o_prdata = {23'h000000, pend_reg, result_reg};
        end else if (sel_cfg) begin
            o_prdata = {15'h0000, cfg_reg};
        end else if (sel_edge) begin
            o_prdata = {24'h000000, edge_reg};
        end else if (sel_state) begin
            o_prdata = {16'h0000, state_bits};
        end else begin
            // Unmapped: zero data with a slave error
            hit = 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- qbp_port_checker.sv ----
`default_nettype none
module qbp_port_checker (
    input wire logic       i_mclk,
    input wire logic       i_reset,
    input wire logic [7:0] i_pin_sense,
    input wire logic [7:0] o_strong_pulldown,
    input wire logic [7:0] o_strong_pullup,
    input wire logic [7:0] o_weak_pullup,
    input wire logic [7:0] o_trip_pullup,
    input wire logic [7:0] o_analog_select
);
    logic [3:0] cnt_reg;
    wire  [7:0] pu_w = o_weak_pullup | o_trip_pullup | o_strong_pullup;
    // Machine-cycle position, S1P1 right after reset
    always_ff @(posedge i_mclk or posedge i_reset) begin
        if (i_reset)
            cnt_reg <= 4'h0;
        else
            cnt_reg <= (cnt_reg == 4'hb) ? 4'h0 : cnt_reg + 4'h1;
    end
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    // Pins 6 and 7 serve analog and compare use, so masked where needed
    a_reset_idle: assert property ($fell(i_reset) |->
        {o_weak_pullup, o_trip_pullup | o_strong_pullup | o_strong_pulldown} == 16'hff00)
        else $error("drive not idle after reset");
    a_pd_excl: assert property ((o_strong_pulldown & pu_w & 8'h7f) == 8'h00)
        else $error("pulldown with pull-up");
    a_weak_latch: assert property (((o_weak_pullup ^ o_strong_pulldown) & 8'h3f) == 8'h3f)
        else $error("weak and pulldown disagree");
    a_trip_sense: assert property ((!i_pin_sense[0]) [*6] |-> !o_trip_pullup[0])
        else $error("trip on while sensed low");
    a_forced_two: assert property ($rose(o_strong_pullup[0]) |=>
        o_strong_pullup[0] ##1 !o_strong_pullup[0]) else $error("forced high not two clocks");
    a_forced_cause: assert property ($rose(o_strong_pullup[0]) |->
        $fell(o_strong_pulldown[0])) else $error("forced high without low before");
    a_pd_s1: assert property ($changed(o_strong_pulldown & 8'h3f) |-> cnt_reg == 4'h1)
        else $error("pin update not at S1P1");
    a_phase_one: assert property ($changed(pu_w & 8'h3f) |-> cnt_reg[0])
        else $error("pull-up change off phase 1");
    a_analog_off: assert property (o_analog_select[6] [*3] |->
        !(pu_w[6] | o_strong_pulldown[6])) else $error("analog pin driven");
endmodule
bind qbp_port qbp_port_checker chk_u (.i_mclk, .i_reset, .i_pin_sense, .o_strong_pulldown,
    .o_strong_pullup, .o_weak_pullup, .o_trip_pullup, .o_analog_select);
`default_nettype wire

// ---- qbp_port_tb.sv ----
`include "qbp_map.vh"
`default_nettype none
module qbp_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, psel, pen, pwr, rdy, serr, se;
    logic [7:0]  addr, cmp, ext, heavy, pin, pd, pu, wk, tp, ana;
    logic [31:0] wd, rdat, r;
    int          err_total, cmp_count;

    qbp_port dut_u (.i_mclk(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wd), .o_pready(rdy), .o_prdata(rdat),
        .o_pslverr(serr), .i_pin(pin), .i_pin_sense(pin), .i_cmp_level(cmp),
        .o_strong_pulldown(pd), .o_strong_pullup(pu), .o_weak_pullup(wk),
        .o_trip_pullup(tp), .o_analog_select(ana));
    qbp_pins pins_u (.i_mclk(clk), .i_reset(rst), .i_pd(pd), .i_pu(pu), .i_weak(wk),
        .i_trip(tp), .i_ext_low(ext), .i_heavy(heavy), .o_pin(pin));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        if (err_total == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Waits for pready under a bound; latch commands may stall a machine cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {psel, pwr, addr, wd} <= {1'b1, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 40);
        r = rdat;
        se = serr;
        {psel, pen} <= 2'b00;
        if (n >= 40) begin
            err_total++;
            test_done();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask

    function automatic logic [31:0] st(input logic [7:0] l, input logic [7:0] p);
        st = 32'h0;
        for (int i = 0; i < 8; i++)
            st[2*i +: 2] = !l[i] ? 2'h3 : (p[i] ? 2'h1 : 2'h0);
    endfunction

    function automatic logic [7:0] opf(input logic [3:0] op, input logic [7:0] l,
                                       input logic [7:0] a, input logic [2:0] b,
                                       input logic c);
        logic [7:0] m;
        m = 8'h01 << b;
        case (op)
            4'h0: opf = l & a;
            4'h1: opf = l | a;
            4'h2: opf = l ^ a;
            4'h4: opf = l ^ m;
            4'h5: opf = l + 8'h01;
            4'h6, 4'h7: opf = l - 8'h01;
            4'h8: opf = c ? (l | m) : (l & ~m);
            4'h3, 4'h9: opf = l & ~m;
            4'ha: opf = l | m;
            4'hb: opf = a;
            default: opf = l;
        endcase
    endfunction

    initial begin
        logic [7:0] v, e, a;
        rst = 1'b1;
        {psel, pen, pwr, addr, wd, cmp, ext, heavy} = '0;
        void'($urandom(68));
        repeat (8) @(posedge clk);
        chk({wk, tp | pu | pd}, 32'hff00);
        rst <= 1'b0;
        rd(`QBP_OFS_LATCH, 32'hff);
        rd(`QBP_OFS_CFG, 32'h0);
        for (int k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'h00 : 8'($urandom);
            e = 8'($urandom);
            ext <= e;
            apb(1'b1, `QBP_OFS_LATCH, {24'h0, v});
            repeat (30) @(posedge clk);
            rd(`QBP_OFS_STATE, st(v, v & ~e));
            chk({24'h0, pd}, {24'h0, ~v});
            rd(`QBP_OFS_PIN, {24'h0, v & ~e});
            rd(`QBP_OFS_LATCH, {24'h0, v});
        end
        ext <= 8'h00;
        apb(1'b1, `QBP_OFS_LATCH, 32'hff);
        repeat (30) @(posedge clk);
        apb(1'b1, `QBP_OFS_EDGE, 32'hff);
        e = 8'($urandom);
        ext <= e;
        repeat (30) @(posedge clk);
        rd(`QBP_OFS_EDGE, {24'h0, e});
        apb(1'b1, `QBP_OFS_EDGE, 32'hff);
        rd(`QBP_OFS_EDGE, 32'h0);
        for (int k = 0; k < 13; k++) begin
            v = 8'($urandom);
            a = 8'($urandom);
            e = 8'($urandom);
            ext <= e;
            apb(1'b1, `QBP_OFS_LATCH, {24'h0, v});
            apb(1'b1, `QBP_OFS_RMW, {15'h0, e[0], a, 1'b0, e[3:1], 4'(k + k / 12 * 2)});
            repeat (26) @(posedge clk);
            rd(`QBP_OFS_LATCH, {24'h0, opf(4'(k + k / 12 * 2), v, a, e[3:1], e[0])});
        end
        // Stuck weak pin revived by a low-then-high latch write
        apb(1'b1, `QBP_OFS_LATCH, 32'hff);
        {heavy, ext} <= 16'h0101;
        repeat (30) @(posedge clk);
        ext <= 8'h00;
        repeat (30) @(posedge clk);
        rd(`QBP_OFS_STATE, 32'h5554);
        apb(1'b1, `QBP_OFS_LATCH, 32'hfe);
        apb(1'b1, `QBP_OFS_LATCH, 32'hff);
        repeat (30) @(posedge clk);
        rd(`QBP_OFS_STATE, 32'h5555);
        heavy <= 8'h00;
        apb(1'b1, `QBP_OFS_CFG, 32'h18040);
        repeat (30) @(posedge clk);
        chk({16'h0, ana, pd & 8'hc0}, 32'h4080);
        rd(`QBP_OFS_PIN, 32'h3f);
        cmp <= 8'h80;
        repeat (30) @(posedge clk);
        chk({24'h0, pd & 8'hc0}, 32'h0);
        rd(`QBP_OFS_PIN, 32'hbf);
        apb(1'b1, `QBP_OFS_CFG, 32'h0);
        repeat (30) @(posedge clk);
        rd(`QBP_OFS_PIN, 32'hff);
        apb(1'b0, 8'h40, 32'h0);
        chk({se, r[30:0]}, 32'h80000000);
        test_done();
    end
endmodule
`default_nettype wire
